// >>> sram_port_pkg.sv
// Shared constants and types for the separate-port DDR SRAM link
package sram_port_pkg;

    // ------------------------------------------------------------------
    // Data and address organisation
    // ------------------------------------------------------------------
    localparam int BYTE_WIDTH    = 9;
    localparam int MAX_LANES     = 4;
    localparam int WIDTH_X9      = 9;
    localparam int WIDTH_X18     = 18;
    localparam int WIDTH_X36     = 36;
    localparam int ADDR_WIDTH_X9  = 22;
    localparam int ADDR_WIDTH_X18 = 21;
    localparam int ADDR_WIDTH_X36 = 20;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_MHZ       = 40;
    localparam int K_PERIOD_CYCLES = 4;
    localparam int DLL_OFF_MAX_MHZ = 167;
    localparam int LINK_MHZ        = CLOCK_MHZ / K_PERIOD_CYCLES;

    // Echo edges counted from the read capture to the first beat
    localparam int          SCHED_WIDTH       = 7;
    localparam logic [2:0]  FIRST_BEAT_BASE   = 3'h3;
    localparam logic [2:0]  FIRST_BEAT_SINGLE = 3'h5;

    // One input clock period split into four system cycles
    typedef enum logic [1:0] {
        PH_K_RISE  = 2'b00,
        PH_ADDR_SW = 2'b01,
        PH_KN_RISE = 2'b10,
        PH_ACCEPT  = 2'b11
    } phase_t;

endpackage

// >>> sram_link_if.sv
// Pin-level link between the SRAM port and its memory controller
`timescale 1ns/1ps
`default_nettype none

interface sram_link_if #(
    parameter int WIDTH  = 36,
    parameter int ADDR_W = 20
);
    localparam int LANES = WIDTH / 9;

    logic              k;
    logic              k_n;
    logic              c;
    logic              c_n;
    logic              read_port_select_n;
    logic              write_port_select_n;
    logic [LANES-1:0]  byte_write_select_n;
    logic [ADDR_W-1:0] addr;
    logic [WIDTH-1:0]  d;
    logic [WIDTH-1:0]  q;
    logic              q_oe;
    logic              echo_clock;
    logic              echo_clock_n;
    logic              dll_disable_n;
    logic              single_clock_mode;

    modport device (
        input  k, k_n, c, c_n, read_port_select_n, write_port_select_n,
        input  byte_write_select_n, addr, d, dll_disable_n, single_clock_mode,
        output q, q_oe, echo_clock, echo_clock_n
    );

    modport controller (
        output k, k_n, c, c_n, read_port_select_n, write_port_select_n,
        output byte_write_select_n, addr, d, dll_disable_n, single_clock_mode,
        input  q, q_oe, echo_clock, echo_clock_n
    );

endinterface

`default_nettype wire

// >>> sram_port_device.sv
// SRAM end of the link: array, write capture, read pipeline, echo clocks
`timescale 1ns/1ps
`default_nettype none

module sram_port_device
    import sram_port_pkg::*;
#(
    parameter int WIDTH  = WIDTH_X36,
    parameter int ADDR_W = ADDR_WIDTH_X36
) (
    input  wire logic  clock,
    input  wire logic  reset_n,
    sram_link_if.device link,
    output logic       array_write,
    output logic       read_driving
);

    localparam int LANES    = WIDTH / BYTE_WIDTH;
    localparam int DEPTH    = 1 << ADDR_W;
    localparam int ADDR_MAX = (WIDTH == WIDTH_X9)  ? ADDR_WIDTH_X9 :
                              (WIDTH == WIDTH_X18) ? ADDR_WIDTH_X18 : ADDR_WIDTH_X36;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (WIDTH != WIDTH_X9 && WIDTH != WIDTH_X18 && WIDTH != WIDTH_X36) begin : g_bad_width
        $error("WIDTH must be 9, 18 or 36");
    end
    if (ADDR_W < 1 || ADDR_W > ADDR_MAX) begin : g_bad_addr
        $error("ADDR_W out of range for this WIDTH");
    end

    typedef struct packed {
        logic              k;
        logic              k_n;
        logic              c;
        logic              c_n;
        logic              wr_pend;
        logic [LANES-1:0]  wr_be0_n;
        logic [WIDTH-1:0]  wr_d0;
        logic              fetch_v;
        logic [WIDTH-1:0]  fetch_w0;
        logic [WIDTH-1:0]  fetch_w1;
        logic              stage_v;
        logic [WIDTH-1:0]  stage_w0;
        logic [WIDTH-1:0]  stage_w1;
        logic              line0_v;
        logic              line1_v;
        logic [WIDTH-1:0]  line0;
        logic [WIDTH-1:0]  line1;
        logic [WIDTH-1:0]  q;
        logic              q_oe;
        logic              echo;
        logic              echo_n;
        logic              wrote;
    } dev_state_t;

    dev_state_t        s;
    dev_state_t        next_s;

    // Two equal arrays: first and second beat of each address
    logic [WIDTH-1:0]  mem_even [DEPTH];
    logic [WIDTH-1:0]  mem_odd  [DEPTH];

    logic              k_rise;
    logic              kn_rise;
    logic              c_rise;
    logic              cn_rise;
    logic              out_rise;
    logic              out_edge;
    logic              dll_on;
    logic              wr_commit;

    // ------------------------------------------------------------------
    // Input clock edges
    // ------------------------------------------------------------------
    // accesses start on K
    assign k_rise   = link.k & ~s.k;
    assign kn_rise  = link.k_n & ~s.k_n;
    assign c_rise   = link.c & ~s.c;
    assign cn_rise  = link.c_n & ~s.c_n;
    assign out_rise = link.single_clock_mode ? k_rise : c_rise;
    assign out_edge = link.single_clock_mode ? (k_rise | kn_rise) : (c_rise | cn_rise);
    assign dll_on   = link.dll_disable_n;
    assign wr_commit = kn_rise & s.wr_pend;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic             emit_v;
        logic [WIDTH-1:0] emit_d;
        emit_v = 1'b0;
        emit_d = s.line0;
        next_s = s;
        next_s.k      = link.k;
        next_s.k_n    = link.k_n;
        next_s.c      = link.c;
        next_s.c_n    = link.c_n;
        next_s.wrote  = wr_commit;

        if (k_rise) begin
            next_s.wr_pend = ~link.write_port_select_n;
            if (!link.write_port_select_n) begin
                next_s.wr_d0    = link.d;
                next_s.wr_be0_n = link.byte_write_select_n;
            end
        end

        if (k_rise) begin
            next_s.fetch_v = ~link.read_port_select_n;
            if (!link.read_port_select_n) begin
                next_s.fetch_w0 = mem_even[link.addr];
                next_s.fetch_w1 = mem_odd[link.addr];
            end
        end

        if (out_edge) begin
            if (out_rise) begin
                next_s.stage_v  = s.fetch_v;
                next_s.stage_w0 = s.fetch_w0;
                next_s.stage_w1 = s.fetch_w1;
                emit_v          = s.line0_v;
                next_s.line0_v  = s.line1_v;
                next_s.line0    = s.line1;
                next_s.line1_v  = 1'b0;
                if (s.stage_v) begin
                    if (!dll_on) begin
                        emit_v         = 1'b1;
                        emit_d         = s.stage_w0;
                        next_s.line0_v = 1'b1;
                        next_s.line0   = s.stage_w1;
                    end else begin
                        next_s.line0_v = 1'b1;
                        next_s.line0   = s.stage_w0;
                        next_s.line1_v = 1'b1;
                        next_s.line1   = s.stage_w1;
                    end
                end
            end else begin
                emit_v         = s.line0_v;
                next_s.line0_v = s.line1_v;
                next_s.line0   = s.line1;
                next_s.line1_v = 1'b0;
            end
            if (emit_v) begin
                next_s.q    = emit_d;
                next_s.q_oe = 1'b1;
            end else if (out_rise) begin
                next_s.q_oe = 1'b0;
            end
        end

        next_s.echo   = link.single_clock_mode ? link.k : link.c;
        next_s.echo_n = link.single_clock_mode ? link.k_n : link.c_n;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{k_n: 1'b1, c_n: 1'b1, echo_n: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Array write, both beats at K-complement
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (wr_commit) begin
            for (int b = 0; b < LANES; b++) begin
                if (!s.wr_be0_n[b]) begin
                    mem_even[link.addr][b*BYTE_WIDTH +: BYTE_WIDTH] <=
                        s.wr_d0[b*BYTE_WIDTH +: BYTE_WIDTH];
                end
                if (!link.byte_write_select_n[b]) begin
                    mem_odd[link.addr][b*BYTE_WIDTH +: BYTE_WIDTH] <=
                        link.d[b*BYTE_WIDTH +: BYTE_WIDTH];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign link.q            = s.q;
    assign link.q_oe         = s.q_oe;
    assign link.echo_clock   = s.echo;
    assign link.echo_clock_n = s.echo_n;
    assign array_write       = s.wrote;
    assign read_driving      = s.q_oe;

endmodule // sram_port_device

`default_nettype wire

// >>> sram_port_controller.sv
// Controller end of the link: input clocks, commands, read capture
`timescale 1ns/1ps
`default_nettype none

module sram_port_controller
    import sram_port_pkg::*;
#(
    parameter int WIDTH  = WIDTH_X36,
    parameter int ADDR_W = ADDR_WIDTH_X36
) (
    input  wire logic               clock,
    input  wire logic               reset_n,
    sram_link_if.controller         link,
    input  wire logic               dll_on,
    input  wire logic               single_clock,
    input  wire logic               rd_req,
    input  wire logic [ADDR_W-1:0]  rd_addr,
    input  wire logic               wr_req,
    input  wire logic [ADDR_W-1:0]  wr_addr,
    input  wire logic [WIDTH-1:0]   wr_data0,
    input  wire logic [WIDTH-1:0]   wr_data1,
    input  wire logic [WIDTH/9-1:0] wr_byte_en0,
    input  wire logic [WIDTH/9-1:0] wr_byte_en1,
    output logic                    req_ready,
    output logic [WIDTH-1:0]        rd_data0,
    output logic [WIDTH-1:0]        rd_data1,
    output logic                    rd_valid
);

    localparam int LANES = WIDTH / BYTE_WIDTH;

    if (WIDTH != WIDTH_X9 && WIDTH != WIDTH_X18 && WIDTH != WIDTH_X36) begin : g_bad_width
        $error("WIDTH must be 9, 18 or 36");
    end
    if (LINK_MHZ > DLL_OFF_MAX_MHZ) begin : g_too_fast
        $error("Input clock rate above the DLL-off limit");
    end

    typedef struct packed {
        phase_t                 phase;
        logic                   k;
        logic                   c;
        logic                   rps_n;
        logic                   wps_n;
        logic [ADDR_W-1:0]      addr;
        logic [WIDTH-1:0]       d;
        logic [LANES-1:0]       bws_n;
        logic [ADDR_W-1:0]      wr_addr_hold;
        logic [WIDTH-1:0]       wr_d1_hold;
        logic [LANES-1:0]       wr_be1_hold;
        logic [SCHED_WIDTH-1:0] sched;
        logic                   echo_q;
        logic                   echo_n_q;
        logic                   have_first;
        logic [WIDTH-1:0]       rd_data0;
        logic [WIDTH-1:0]       rd_data1;
        logic                   rd_valid;
        logic                   dll_disable_n;
        logic                   single;
    } ctl_state_t;

    ctl_state_t        s;
    ctl_state_t        next_s;
    logic              echo_edge;
    logic [2:0]        first_pos;

    assign echo_edge = (link.echo_clock & ~s.echo_q) | (link.echo_clock_n & ~s.echo_n_q);
    assign first_pos = (s.single ? FIRST_BEAT_SINGLE : FIRST_BEAT_BASE)
                     + {2'h0, s.dll_disable_n};
    assign req_ready = (s.phase == PH_ACCEPT);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.rd_valid      = 1'b0;
        next_s.echo_q        = link.echo_clock;
        next_s.echo_n_q      = link.echo_clock_n;
        next_s.dll_disable_n = dll_on;
        next_s.single        = single_clock;

        unique case (s.phase)
            PH_K_RISE:  next_s.phase = PH_ADDR_SW;
            PH_ADDR_SW: next_s.phase = PH_KN_RISE;
            PH_KN_RISE: next_s.phase = PH_ACCEPT;
            PH_ACCEPT:  next_s.phase = PH_K_RISE;
        endcase

        next_s.k = (next_s.phase == PH_K_RISE) || (next_s.phase == PH_ADDR_SW);
        // C pair complementary, one cycle behind K; both held high in single clock mode
        next_s.c = single_clock ||
                   (next_s.phase == PH_ADDR_SW) || (next_s.phase == PH_KN_RISE);

        if (s.phase == PH_ACCEPT) begin
            next_s.rps_n = ~rd_req;
            next_s.wps_n = ~wr_req;
            next_s.addr  = rd_addr;
            next_s.d     = wr_data0;
            next_s.bws_n = ~wr_byte_en0;
            next_s.wr_addr_hold = wr_addr;
            next_s.wr_d1_hold   = wr_data1;
            next_s.wr_be1_hold  = wr_byte_en1;
        end else if (s.phase == PH_ADDR_SW) begin
            next_s.rps_n = 1'b1;
            next_s.wps_n = 1'b1;
            next_s.addr  = s.wr_addr_hold;
            next_s.d     = s.wr_d1_hold;
            next_s.bws_n = ~s.wr_be1_hold;
        end

        // Read beats counted in echo edges after the K capture
        if (echo_edge) begin
            next_s.sched = s.sched >> 1;
            if (s.sched[0] && link.q_oe) begin
                if (!s.have_first) begin
                    next_s.rd_data0   = link.q;
                    next_s.have_first = 1'b1;
                end else begin
                    next_s.rd_data1   = link.q;
                    next_s.have_first = 1'b0;
                    next_s.rd_valid   = 1'b1;
                end
            end
        end
        if (s.phase == PH_K_RISE && !s.rps_n) begin
            next_s.sched = next_s.sched
                         | (SCHED_WIDTH'(3) << (first_pos - 3'h1));
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{phase: PH_ACCEPT, rps_n: 1'b1, wps_n: 1'b1,
                   bws_n: '1, dll_disable_n: 1'b1, echo_n_q: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign link.k                   = s.k;
    assign link.k_n                 = ~s.k;
    assign link.c                   = s.c;
    assign link.c_n                 = s.single | ~s.c;
    assign link.read_port_select_n  = s.rps_n;
    assign link.write_port_select_n = s.wps_n;
    assign link.byte_write_select_n = s.bws_n;
    assign link.addr                = s.addr;
    assign link.d                   = s.d;
    assign link.dll_disable_n       = s.dll_disable_n;
    assign link.single_clock_mode   = s.single;
    assign rd_data0                 = s.rd_data0;
    assign rd_data1                 = s.rd_data1;
    assign rd_valid                 = s.rd_valid;

endmodule // sram_port_controller

`default_nettype wire

// >>> sram_port_asserts.sv
// Checker of the link between the SRAM port and its controller
`timescale 1ns/1ps
`default_nettype none

module sram_port_asserts #(
    parameter int WIDTH  = 36,
    parameter int ADDR_W = 20
) (
    input wire logic                 clock,
    input wire logic                 reset_n,
    input wire logic                 k,
    input wire logic                 k_n,
    input wire logic                 c,
    input wire logic                 c_n,
    input wire logic                 read_port_select_n,
    input wire logic                 write_port_select_n,
    input wire logic [WIDTH/9-1:0]   byte_write_select_n,
    input wire logic [ADDR_W-1:0]    addr,
    input wire logic [WIDTH-1:0]     d,
    input wire logic                 q_oe,
    input wire logic                 echo_clock,
    input wire logic                 echo_clock_n,
    input wire logic                 dll_disable_n,
    input wire logic                 single_clock_mode
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [5:0] since_read;

    default clocking main_cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // Cycles since the last read capture, saturating
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            since_read <= 6'h3f;
        end else if ($rose(k) && !read_port_select_n) begin
            since_read <= 6'h00;
        end else if (since_read != 6'h3f) begin
            since_read <= since_read + 6'h01;
        end
    end

    // Read captured with the output pipeline quiet
    sequence lone_read_s;
        $rose(k) && !read_port_select_n && since_read > 6'h14;
    endsequence

    sequence c_run_s;
        $rose(k) ##0 (!single_clock_mode) [*4];
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    k_period_a: assert property ($rose(k) |-> ##1 k ##1 !k ##1 !k ##1 k)
        else $error("input clock period wrong");
    c_phase_a: assert property (
        c_run_s |-> !c && $past(c) && $past(c, 2) && !$past(c, 3))
        else $error("output clock out of phase with input clock");
    c_pair_a: assert property (!single_clock_mode |-> c_n != c)
        else $error("output clocks not complementary");
    single_hold_a: assert property (
        single_clock_mode && $stable(single_clock_mode) |-> c && c_n)
        else $error("output clocks not held high in single clock mode");
    echo_follow_a: assert property ($stable(single_clock_mode) |->
        echo_clock == (single_clock_mode ? $past(k) : $past(c)))
        else $error("echo clock does not follow its reference");
    echo_anti_a: assert property ($stable(single_clock_mode) |->
        echo_clock_n == (single_clock_mode ? $past(k_n) : $past(c_n)))
        else $error("complementary echo clock does not follow its reference");
    wsel_on_k_a: assert property ($fell(write_port_select_n) |-> $rose(k))
        else $error("write select not aligned to input clock rise");
    rsel_span_a: assert property ($fell(read_port_select_n) |->
        $rose(k) ##1 !read_port_select_n ##1 read_port_select_n)
        else $error("read select window wrong");
    hold_k_a: assert property ($changed(k) |=>
        $stable(addr) && $stable(d) && $stable(byte_write_select_n))
        else $error("address or data moved inside a capture slot");
    q_float_a: assert property (q_oe |-> since_read < 6'h10)
        else $error("read outputs driven without a pending read");
    dll_off_lat_a: assert property (
        lone_read_s ##0 (!dll_disable_n && !single_clock_mode)
        |-> ##1 (!q_oe) [*5] ##1 q_oe)
        else $error("read data late with loop off");
    dll_on_lat_a: assert property (
        lone_read_s ##0 (dll_disable_n && !single_clock_mode)
        |-> ##1 (!q_oe) [*7] ##1 q_oe)
        else $error("read data latency wrong with loop on");
endmodule // sram_port_asserts

`default_nettype wire

// >>> ddr_separate_io_sram_port_tb.sv
// Self-checking bench: controller and SRAM port joined by the link
`timescale 1ns/1ps
`default_nettype none

module ddr_separate_io_sram_port_tb;
    import sram_port_pkg::*;

    localparam int W  = WIDTH_X36;
    localparam int AW = 8;
    localparam int LN = W / BYTE_WIDTH;

    logic          clock        = 1'b0;
    logic          reset_n      = 1'b0;
    logic          dll_on       = 1'b1;
    logic          single_clock = 1'b0;
    logic          rd_req       = 1'b0;
    logic          wr_req       = 1'b0;
    logic [AW-1:0] rd_addr      = '0;
    logic [AW-1:0] wr_addr      = '0;
    logic [W-1:0]  wr_data0     = '0;
    logic [W-1:0]  wr_data1     = '0;
    logic [LN-1:0] wr_byte_en0  = '0;
    logic [LN-1:0] wr_byte_en1  = '0;
    logic          req_ready;
    logic          rd_valid;
    logic          array_write;
    logic          read_driving;
    logic [W-1:0]  rd_data0;
    logic [W-1:0]  rd_data1;
    int            fail_count   = 0;
    int            num_checks   = 0;
    int            cycles       = 0;

    sram_link_if #(.WIDTH(W), .ADDR_W(AW)) link ();
    sram_port_device #(.WIDTH(W), .ADDR_W(AW)) sram_port_device_inst (
        .clock, .reset_n, .link, .array_write, .read_driving);
    sram_port_controller #(.WIDTH(W), .ADDR_W(AW)) sram_port_controller_inst (
        .clock, .reset_n, .link, .dll_on, .single_clock, .rd_req, .rd_addr, .wr_req,
        .wr_addr, .wr_data0, .wr_data1, .wr_byte_en0, .wr_byte_en1, .req_ready,
        .rd_data0, .rd_data1, .rd_valid);
    sram_port_asserts #(.WIDTH(W), .ADDR_W(AW)) sram_port_asserts_inst (
        .clock, .reset_n, .k(link.k), .k_n(link.k_n), .c(link.c), .c_n(link.c_n),
        .read_port_select_n(link.read_port_select_n),
        .write_port_select_n(link.write_port_select_n),
        .byte_write_select_n(link.byte_write_select_n), .addr(link.addr), .d(link.d),
        .q_oe(link.q_oe), .echo_clock(link.echo_clock), .echo_clock_n(link.echo_clock_n),
        .dll_disable_n(link.dll_disable_n), .single_clock_mode(link.single_clock_mode));

    always #12.5 clock = ~clock;

    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(string what, logic [W-1:0] exp, logic [W-1:0] got_v);
        num_checks++;
        if (got_v !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got_v);
        end
    endtask

    function automatic logic [W-1:0] merge(logic [W-1:0] old, logic [W-1:0] nw,
                                           logic [LN-1:0] en);
        merge = old;
        for (int i = 0; i < LN; i++) begin
            if (en[i]) begin
                merge[i*9 +: 9] = nw[i*9 +: 9];
            end
        end
    endfunction

    // Offer a request and hold it until the accepting edge
    task automatic issue(logic rd, logic [AW-1:0] ra, logic wr, logic [AW-1:0] wa,
                         logic [W-1:0] d0, logic [W-1:0] d1, logic [LN-1:0] e0,
                         logic [LN-1:0] e1);
        int n;
        n = 0;
        @(posedge clock);
        rd_req      <= rd;
        rd_addr     <= ra;
        wr_req      <= wr;
        wr_addr     <= wa;
        wr_data0    <= d0;
        wr_data1    <= d1;
        wr_byte_en0 <= e0;
        wr_byte_en1 <= e1;
        do begin
            @(negedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 8);
        @(posedge clock);
        rd_req <= 1'b0;
        wr_req <= 1'b0;
    endtask

    task automatic wr(logic [AW-1:0] a, logic [W-1:0] d0, logic [W-1:0] d1,
                      logic [LN-1:0] e0, logic [LN-1:0] e1);
        issue(1'b0, a, 1'b1, a, d0, d1, e0, e1);
    endtask

    task automatic rd(logic [AW-1:0] a);
        issue(1'b1, a, 1'b0, a, '0, '0, '0, '0);
    endtask

    // Wait for the next read completion and compare both words
    task automatic got(logic [W-1:0] e0, logic [W-1:0] e1, output int n);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (rd_valid !== 1'b1 && n < 64);
        check("rd_valid", 36'h1, W'(rd_valid));
        check("rd_data0", e0, rd_data0);
        check("rd_data1", e1, rd_data1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_basic();
        int n;
        wr(8'h11, 36'h1_2345_6789, 36'h9_8765_4321, 4'hf, 4'hf);
        n = 0;
        while (array_write !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        check("array_write", 36'h1, W'(array_write));
        rd(8'h11);
        got(36'h1_2345_6789, 36'h9_8765_4321, n);
    endtask

    task automatic t_mask();
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        int           n;
        e0 = merge(36'h1_1111_1111, 36'hc_cccc_cccc, 4'h5);
        e1 = merge(36'h2_2222_2222, 36'h3_3333_3333, 4'ha);
        wr(8'h22, 36'h1_1111_1111, 36'h2_2222_2222, 4'hf, 4'hf);
        wr(8'h22, 36'hc_cccc_cccc, 36'h3_3333_3333, 4'h5, 4'ha);
        wr(8'h22, 36'h0, 36'h0, 4'h0, 4'h0);
        rd(8'h22);
        got(e0, e1, n);
    endtask

    task automatic t_shared_addr();
        int n;
        issue(1'b1, 8'h11, 1'b1, 8'h33, 36'h5_0505_0505, 36'h6_0606_0606, 4'hf, 4'hf);
        got(36'h1_2345_6789, 36'h9_8765_4321, n);
        issue(1'b1, 8'h33, 1'b0, 8'h33, 36'h7_7777_7777, 36'h8_8888_8888, 4'hf, 4'hf);
        got(36'h5_0505_0505, 36'h6_0606_0606, n);
    endtask

    task automatic t_back_to_back();
        int n;
        rd(8'h11);
        rd(8'h33);
        got(36'h1_2345_6789, 36'h9_8765_4321, n);
        got(36'h5_0505_0505, 36'h6_0606_0606, n);
    endtask

    task automatic t_idle();
        repeat (20) @(negedge clock);
        check("q_oe", 36'h0, W'(link.q_oe));
        check("read_driving", 36'h0, W'(read_driving));
    endtask

    // Every combination of loop and single clock mode
    task automatic t_modes();
        int lat [4];
        for (int m = 0; m < 4; m++) begin
            repeat (8) @(posedge clock);
            dll_on       <= m[0];
            single_clock <= m[1];
            repeat (24) @(posedge clock);
            wr(8'h40, W'(m), ~W'(m), 4'hf, 4'hf);
            rd(8'h40);
            got(W'(m), ~W'(m), lat[m]);
        end
        check("loop off sooner", 36'h1, W'(lat[0] < lat[1]));
        check("loop off sooner single", 36'h1, W'(lat[2] < lat[3]));
        repeat (8) @(posedge clock);
        dll_on       <= 1'b1;
        single_clock <= 1'b0;
        repeat (24) @(posedge clock);
    endtask

    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        t_idle();
        t_basic();
        t_mask();
        t_shared_addr();
        t_back_to_back();
        t_idle();
        t_modes();
        stop_test();
    end
endmodule // ddr_separate_io_sram_port_tb

`default_nettype wire
